// ---- logic/isp_pkg.sv ----
// Notes on behaviour
// - Simultaneous pending requests are served lowest priority number first, 0 highest.
// - Low-voltage request, priority 0, vector 0004h, only while detector mode bit is 0.
// - Four external pin edge requests, priorities 1 to 4, vectors 0006h to 000ch.
// - Serial unit B receive error, priority 5, vector 0012h.
// - Serial unit B receive complete, priority 6, vector 0014h.
// - Serial unit B transmit complete, priority 7, vector 0016h.
// - Clocked serial done and serial A transmit done share priority 8, vector 0018h.
// - Timer H1 compare match in compare mode, priority 9, vector 001ah.
// - Timer H0 compare match in compare mode, priority 10, vector 001ch.
// - Eight-bit timer A compare match in compare mode, priority 11, vector 001eh.
// - Timer16 channel A: first compare match, or pin B edge in capture mode; 0020h.
// - Timer16 channel B: second compare match, or pin A edge in capture mode; 0022h.
// - Conversion done, priority 14, vector 0024h, only on variant with converter.
// - Serial unit A receive done or receive error share priority 15, vector 0026h.
// - Counter fixed-cycle and alarm match share priority 16, vector 0028h.
// - Eight-bit timer B compare match in compare mode, priority 17, vector 002ah.
// - In carrier mode timer B request follows carrier transfer signal, not compare match.
// - Key input priority 18 vector 002ch; counter interval priority 19 vector 002eh.
`default_nettype none
package isp_pkg;
    localparam int ISP_NUM_SRC = 20;
    localparam int ISP_IDX_W = 5;
    localparam int ISP_VEC_W = 16;

    // Source index equals default priority
    localparam logic [ISP_IDX_W-1:0] ISP_IDX_LVI = 5'h00;
    localparam logic [ISP_IDX_W-1:0] ISP_IDX_T16A = 5'h0c;
    localparam logic [ISP_IDX_W-1:0] ISP_IDX_CONV = 5'h0e;
    localparam logic [ISP_IDX_W-1:0] ISP_IDX_T8B = 5'h11;

    localparam logic [ISP_NUM_SRC-1:0] ISP_FLAGS_RESET = 20'h00000;
    localparam logic [ISP_VEC_W-1:0] ISP_VECTOR_RESET = 16'h0000;

    // Vector table address per priority level
    localparam logic [ISP_VEC_W-1:0] ISP_VEC_TABLE [ISP_NUM_SRC] = '{
        16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
        16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a,
        16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
        16'h0026, 16'h0028, 16'h002a, 16'h002c, 16'h002e
    };

    typedef enum logic [1:0] {
        ISP_IDLE = 2'b00,
        ISP_HOLD = 2'b01
    } isp_state_t;

    function automatic logic [ISP_VEC_W-1:0] isp_vector(input logic [ISP_IDX_W-1:0] idx);
        isp_vector = ISP_VEC_TABLE[idx];
    endfunction
endpackage
`default_nettype wire

// ---- logic/isp_enc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface isp_enc_if;
    import isp_pkg::*;
    logic [ISP_NUM_SRC-1:0] pending;
    logic [ISP_IDX_W-1:0] win_idx;
    logic win_valid;
    modport enc (input pending, output win_idx, output win_valid);
    modport ctl (output pending, input win_idx, input win_valid);
endinterface
`default_nettype wire

// ---- logic/isp_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module isp_encoder
    import isp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    isp_enc_if.enc bus
);
    logic [ISP_IDX_W-1:0] pick;
    logic found;
    logic [ISP_IDX_W-1:0] win_idx_reg;
    logic win_valid_reg;
    logic [ISP_NUM_SRC-1:0] pend_prev;

    // Scan from the bottom level down; the last hit, lowest index, wins
    always_comb begin
        pick = '0;
        found = 1'b0;
        for (int i = ISP_NUM_SRC - 1; i >= 0; i--) begin
            if (bus.pending[i]) begin
                pick = ISP_IDX_W'(i);
                found = 1'b1;
            end
        end
    end

    // Registered result keeps the long compare chain off the grant path
    always_ff @(posedge clk) begin
        if (rst) begin
            win_idx_reg <= '0;
            win_valid_reg <= 1'b0;
            pend_prev <= '0;
        end else begin
            win_idx_reg <= pick;
            win_valid_reg <= found;
            pend_prev <= bus.pending;
        end
    end

    assign bus.win_idx = win_idx_reg;
    assign bus.win_valid = win_valid_reg;

    // Checks on the priority pick
    wire [ISP_NUM_SRC-1:0] below_win = (20'h00001 << win_idx_reg) - 20'h00001;

    AST_NO_HIGHER_PENDING: assert property (@(posedge clk) disable iff (rst)
        win_valid_reg |-> ((pend_prev & below_win) == 20'h00000)
    ) else $error("a higher priority request was passed over");

    AST_WINNER_IS_PENDING: assert property (@(posedge clk) disable iff (rst)
        win_valid_reg |-> pend_prev[win_idx_reg]
    ) else $error("winner was not pending");

    COV_TWO_AT_ONCE: cover property (@(posedge clk) disable iff (rst)
        $countones(bus.pending) >= 2 ##1 win_valid_reg);
endmodule // isp_encoder
`default_nettype wire

// ---- logic/isp_prioritizer.sv ----
`timescale 1ns/1ps
`default_nettype none
module isp_prioritizer
    import isp_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1
)
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Event pulses from peripherals and external pins, with the mode bits that gate them
    input wire logic LOW_VOLTAGE_REQUEST,
    input wire logic VOLTAGE_DETECT_MODE_BIT,
    input wire logic EXT_PIN_REQUEST_A,
    input wire logic EXT_PIN_REQUEST_B,
    input wire logic EXT_PIN_REQUEST_C,
    input wire logic EXT_PIN_REQUEST_D,
    input wire logic SERIAL_B_RX_ERROR_REQUEST,
    input wire logic SERIAL_B_RX_DONE_REQUEST,
    input wire logic SERIAL_B_TX_DONE_REQUEST,
    input wire logic CLOCKED_SERIAL_DONE_REQUEST,
    input wire logic SERIAL_A_TX_DONE_REQUEST,
    input wire logic TIMER_H_ONE_MATCH_REQUEST,
    input wire logic TIMER_H_ONE_COMPARE_MODE,
    input wire logic TIMER_H_ZERO_MATCH_REQUEST,
    input wire logic TIMER_H_ZERO_COMPARE_MODE,
    input wire logic TIMER_EIGHT_A_MATCH_REQUEST,
    input wire logic TIMER_EIGHT_A_COMPARE_MODE,
    input wire logic TIMER16_MATCH_A,
    input wire logic TIMER16_MATCH_B,
    input wire logic TIMER16_CAPTURE_MODE,
    input wire logic TIMER16_INPUT_PIN_A_EDGE,
    input wire logic TIMER16_INPUT_PIN_B_EDGE,
    input wire logic CONVERSION_DONE_REQUEST,
    input wire logic SERIAL_A_RX_DONE,
    input wire logic SERIAL_A_RX_ERROR,
    input wire logic RTC_CYCLE,
    input wire logic RTC_ALARM,
    input wire logic TIMER_EIGHT_B_MATCH_REQUEST,
    input wire logic TIMER_EIGHT_B_COMPARE_MODE,
    input wire logic CARRIER_MODE,
    input wire logic CARRIER_TRANSFER_SIGNAL,
    input wire logic KEY_INPUT_REQUEST,
    input wire logic RTC_INTERVAL_REQUEST,
    // Per-source mask, one bit per priority level
    input wire logic [ISP_NUM_SRC-1:0] SOURCE_MASK,
    // Core handshake
    input wire logic CPU_ACK,
    input wire logic CPU_FETCH_DONE,
    output logic INT_REQUEST,
    output logic [ISP_VEC_W-1:0] VECTOR_ADDR,
    output logic VECTOR_VALID,
    output logic [ISP_NUM_SRC-1:0] PENDING_FLAGS
);
    isp_enc_if enc_bus ();

    logic [ISP_NUM_SRC-1:0] raw_req;
    logic [ISP_NUM_SRC-1:0] flag_reg;
    logic [ISP_NUM_SRC-1:0] flag_next;
    logic [ISP_NUM_SRC-1:0] clr_vec;
    isp_state_t state_reg;
    isp_state_t state_next;
    logic int_request_reg;
    logic int_request_next;
    logic [ISP_VEC_W-1:0] vector_reg;
    logic [ISP_VEC_W-1:0] vector_next;
    logic vector_valid_reg;
    logic vector_valid_next;
    logic [ISP_IDX_W-1:0] grant_idx_reg;

    // Source conditioning: modes decide which event raises each level
    assign raw_req[0] = LOW_VOLTAGE_REQUEST && !VOLTAGE_DETECT_MODE_BIT;
    assign raw_req[1] = EXT_PIN_REQUEST_A;
    assign raw_req[2] = EXT_PIN_REQUEST_B;
    assign raw_req[3] = EXT_PIN_REQUEST_C;
    assign raw_req[4] = EXT_PIN_REQUEST_D;
    assign raw_req[5] = SERIAL_B_RX_ERROR_REQUEST;
    assign raw_req[6] = SERIAL_B_RX_DONE_REQUEST;
    assign raw_req[7] = SERIAL_B_TX_DONE_REQUEST;
    assign raw_req[8] = CLOCKED_SERIAL_DONE_REQUEST || SERIAL_A_TX_DONE_REQUEST;
    assign raw_req[9] = TIMER_H_ONE_MATCH_REQUEST && TIMER_H_ONE_COMPARE_MODE;
    assign raw_req[10] = TIMER_H_ZERO_MATCH_REQUEST && TIMER_H_ZERO_COMPARE_MODE;
    assign raw_req[11] = TIMER_EIGHT_A_MATCH_REQUEST && TIMER_EIGHT_A_COMPARE_MODE;
    // Capture mode swaps the cause; note the pins cross over
    assign raw_req[12] = TIMER16_CAPTURE_MODE ? TIMER16_INPUT_PIN_B_EDGE
                                              : TIMER16_MATCH_A;
    assign raw_req[13] = TIMER16_CAPTURE_MODE ? TIMER16_INPUT_PIN_A_EDGE
                                              : TIMER16_MATCH_B;
    // Tied off on the variant without a converter
    assign raw_req[14] = HAS_CONVERTER && CONVERSION_DONE_REQUEST;
    assign raw_req[15] = SERIAL_A_RX_DONE || SERIAL_A_RX_ERROR;
    assign raw_req[16] = RTC_CYCLE || RTC_ALARM;
    // Carrier mode ignores plain matches of timer B
    assign raw_req[17] = CARRIER_MODE ? CARRIER_TRANSFER_SIGNAL
        : (TIMER_EIGHT_B_MATCH_REQUEST && TIMER_EIGHT_B_COMPARE_MODE);
    assign raw_req[18] = KEY_INPUT_REQUEST;
    assign raw_req[19] = RTC_INTERVAL_REQUEST;

    // Handshake decode
    wire take = (state_reg == ISP_IDLE) && int_request_reg && CPU_ACK;
    wire release_vec = (state_reg == ISP_HOLD) && CPU_FETCH_DONE;

    // Only the granted level is cleared, and only on a taken acknowledge
    assign clr_vec = take ? (20'h00001 << grant_idx_reg) : 20'h00000;

    // Sticky flags; a new event in the clear cycle survives
    generate
        for (genvar g = 0; g < ISP_NUM_SRC; g++) begin : g_flag
            assign flag_next[g] = raw_req[g] || (flag_reg[g] && !clr_vec[g]);
        end
    endgenerate

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            flag_reg <= ISP_FLAGS_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign enc_bus.pending = flag_reg & ~SOURCE_MASK;

    isp_encoder u_enc (
        .clk(CORE_CLK),
        .rst(RESET),
        .bus(enc_bus)
    );

    // Grant state: idle offers a request, hold freezes the vector
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ISP_IDLE: begin
                if (take) begin
                    state_next = ISP_HOLD;
                end
            end
            ISP_HOLD: begin
                if (release_vec) begin
                    state_next = ISP_IDLE;
                end
            end
            default: state_next = ISP_IDLE;
        endcase
    end

    // Request drops while a vector is held; the encoder result is one
    // cycle old, so the cleared flag is gone before hold ends
    assign int_request_next = (state_next == ISP_IDLE) && !release_vec
                              && !take && enc_bus.win_valid;
    assign vector_next = take ? isp_vector(grant_idx_reg) : vector_reg;
    assign vector_valid_next = take || (vector_valid_reg && !release_vec);

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_reg <= ISP_IDLE;
            int_request_reg <= 1'b0;
            vector_reg <= ISP_VECTOR_RESET;
            vector_valid_reg <= 1'b0;
            grant_idx_reg <= '0;
        end else begin
            state_reg <= state_next;
            int_request_reg <= int_request_next;
            vector_reg <= vector_next;
            vector_valid_reg <= vector_valid_next;
            if (int_request_next) begin
                grant_idx_reg <= enc_bus.win_idx;
            end
        end
    end

    // Winner index is reloaded each cycle the request is raised, so ack clears and vectors one choice
    assign INT_REQUEST = int_request_reg;
    assign VECTOR_ADDR = vector_reg;
    assign VECTOR_VALID = vector_valid_reg;
    assign PENDING_FLAGS = flag_reg;

    // Checks
    AST_LVI_GATED: assert property (@(posedge CORE_CLK) disable iff (RESET)
        VOLTAGE_DETECT_MODE_BIT && !flag_reg[0] |=> !flag_reg[0]
    ) else $error("low-voltage flag set while mode bit is one");

    AST_PIN_EDGE_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        EXT_PIN_REQUEST_D |=> flag_reg[4]
    ) else $error("pin D edge did not set its flag");

    AST_SERIAL_B: assert property (@(posedge CORE_CLK) disable iff (RESET)
        SERIAL_B_RX_ERROR_REQUEST |=> flag_reg[5]
    ) else $error("serial B error flag not set");

    AST_SHARED_EIGHT: assert property (@(posedge CORE_CLK) disable iff (RESET)
        SERIAL_A_TX_DONE_REQUEST || CLOCKED_SERIAL_DONE_REQUEST |=> flag_reg[8]
    ) else $error("shared level 8 flag not set");

    AST_T16_CAPTURE: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER16_CAPTURE_MODE && TIMER16_MATCH_A && !TIMER16_INPUT_PIN_B_EDGE
        && !flag_reg[12] |=> !flag_reg[12]
    ) else $error("compare match raised channel A in capture mode");

    AST_T16_PIN_SWAP: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER16_CAPTURE_MODE && TIMER16_INPUT_PIN_A_EDGE |=> flag_reg[13]
    ) else $error("pin A edge did not raise channel B");

    AST_NO_CONVERTER: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!HAS_CONVERTER |-> !flag_reg[ISP_IDX_CONV])
        and (CONVERSION_DONE_REQUEST |=> flag_reg[ISP_IDX_CONV] == HAS_CONVERTER)
    ) else $error("conversion flag does not follow the variant");

    AST_CARRIER: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CARRIER_MODE && !CARRIER_TRANSFER_SIGNAL && !flag_reg[ISP_IDX_T8B]
        |=> !flag_reg[ISP_IDX_T8B]
    ) else $error("timer B raised outside carrier transfer");

    AST_VECTOR_MAP: assert property (@(posedge CORE_CLK) disable iff (RESET)
        take |=> VECTOR_VALID && VECTOR_ADDR == isp_vector($past(grant_idx_reg))
    ) else $error("vector does not match granted level");

    AST_VECTOR_HOLD: assert property (@(posedge CORE_CLK) disable iff (RESET)
        VECTOR_VALID && !CPU_FETCH_DONE |=> VECTOR_VALID && $stable(VECTOR_ADDR)
    ) else $error("vector changed before fetch done");

    AST_ACK_CLEARS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        take && !raw_req[grant_idx_reg] |=> !flag_reg[$past(grant_idx_reg)]
    ) else $error("granted flag not cleared");

    // Each enabled source lands on its own level one cycle after the event
    AST_LOW_VOLT_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        LOW_VOLTAGE_REQUEST && !VOLTAGE_DETECT_MODE_BIT |=> flag_reg[0]
    ) else $error("low-voltage flag not set");

    AST_PIN_A_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        EXT_PIN_REQUEST_A |=> flag_reg[1]
    ) else $error("pin A edge did not set its flag");

    AST_PIN_B_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        EXT_PIN_REQUEST_B |=> flag_reg[2]
    ) else $error("pin B edge did not set its flag");

    AST_PIN_C_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        EXT_PIN_REQUEST_C |=> flag_reg[3]
    ) else $error("pin C edge did not set its flag");

    AST_SERIAL_B_RX_DONE: assert property (@(posedge CORE_CLK) disable iff (RESET)
        SERIAL_B_RX_DONE_REQUEST |=> flag_reg[6]
    ) else $error("serial B receive flag not set");

    AST_SERIAL_B_TX_DONE: assert property (@(posedge CORE_CLK) disable iff (RESET)
        SERIAL_B_TX_DONE_REQUEST |=> flag_reg[7]
    ) else $error("serial B transmit flag not set");

    AST_TIMER_H_ONE: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER_H_ONE_MATCH_REQUEST && TIMER_H_ONE_COMPARE_MODE |=> flag_reg[9]
    ) else $error("timer H1 flag not set");

    AST_TIMER_H_ZERO: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER_H_ZERO_MATCH_REQUEST && TIMER_H_ZERO_COMPARE_MODE |=> flag_reg[10]
    ) else $error("timer H0 flag not set");

    AST_TIMER_EIGHT_A: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER_EIGHT_A_MATCH_REQUEST && TIMER_EIGHT_A_COMPARE_MODE |=> flag_reg[11]
    ) else $error("timer A flag not set");

    AST_T16_MATCH_A: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !TIMER16_CAPTURE_MODE && TIMER16_MATCH_A |=> flag_reg[12]
    ) else $error("first match did not raise channel A");

    AST_T16_PIN_B: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER16_CAPTURE_MODE && TIMER16_INPUT_PIN_B_EDGE |=> flag_reg[12]
    ) else $error("pin B edge did not raise channel A");

    AST_T16_MATCH_B: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !TIMER16_CAPTURE_MODE && TIMER16_MATCH_B |=> flag_reg[13]
    ) else $error("second match did not raise channel B");

    AST_T16_NO_MATCH_B: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER16_CAPTURE_MODE && TIMER16_MATCH_B && !TIMER16_INPUT_PIN_A_EDGE
        && !flag_reg[13] |=> !flag_reg[13]
    ) else $error("compare match raised channel B in capture mode");

    AST_SERIAL_A_RX: assert property (@(posedge CORE_CLK) disable iff (RESET)
        SERIAL_A_RX_DONE || SERIAL_A_RX_ERROR |=> flag_reg[15]
    ) else $error("serial A receive flag not set");

    AST_RTC_SHARED: assert property (@(posedge CORE_CLK) disable iff (RESET)
        RTC_CYCLE || RTC_ALARM |=> flag_reg[16]
    ) else $error("counter cycle or alarm flag not set");

    AST_TIMER_EIGHT_B: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !CARRIER_MODE && TIMER_EIGHT_B_MATCH_REQUEST && TIMER_EIGHT_B_COMPARE_MODE
        |=> flag_reg[ISP_IDX_T8B]
    ) else $error("timer B flag not set");

    AST_CARRIER_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CARRIER_MODE && CARRIER_TRANSFER_SIGNAL |=> flag_reg[ISP_IDX_T8B]
    ) else $error("carrier transfer did not raise timer B");

    AST_KEY_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        KEY_INPUT_REQUEST |=> flag_reg[18]
    ) else $error("key input flag not set");

    AST_INTERVAL_SETS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        RTC_INTERVAL_REQUEST |=> flag_reg[19]
    ) else $error("counter interval flag not set");

    // Compare mode off: the level has no other cause, so it must stay clear
    AST_H_ONE_MODE_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !TIMER_H_ONE_COMPARE_MODE && !flag_reg[9] |=> !flag_reg[9]
    ) else $error("timer H1 flag set outside compare mode");

    AST_H_ZERO_MODE_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !TIMER_H_ZERO_COMPARE_MODE && !flag_reg[10] |=> !flag_reg[10]
    ) else $error("timer H0 flag set outside compare mode");

    AST_EIGHT_A_MODE_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !TIMER_EIGHT_A_COMPARE_MODE && !flag_reg[11] |=> !flag_reg[11]
    ) else $error("timer A flag set outside compare mode");

    // Handshake shape: one offer or one held vector, never both
    AST_NO_REQ_IN_HOLD: assert property (@(posedge CORE_CLK) disable iff (RESET)
        state_reg == ISP_HOLD |-> !INT_REQUEST
    ) else $error("request offered while a vector is held");

    AST_REQ_NOT_WITH_VEC: assert property (@(posedge CORE_CLK) disable iff (RESET)
        INT_REQUEST |-> !VECTOR_VALID
    ) else $error("request and vector shown together");

    AST_DROP_ON_TAKE: assert property (@(posedge CORE_CLK) disable iff (RESET)
        take |=> !INT_REQUEST
    ) else $error("request stayed up after acknowledge");

    AST_FETCH_ENDS: assert property (@(posedge CORE_CLK) disable iff (RESET)
        VECTOR_VALID && CPU_FETCH_DONE |=> !VECTOR_VALID
    ) else $error("vector still valid after fetch done");

    COV_GRANT: cover property (@(posedge CORE_CLK) disable iff (RESET)
        take ##[1:4] release_vec);
    COV_CAPTURE: cover property (@(posedge CORE_CLK) disable iff (RESET)
        TIMER16_CAPTURE_MODE && TIMER16_INPUT_PIN_B_EDGE);
    COV_CARRIER: cover property (@(posedge CORE_CLK) disable iff (RESET)
        CARRIER_MODE && CARRIER_TRANSFER_SIGNAL);
    COV_SET_AND_CLEAR: cover property (@(posedge CORE_CLK) disable iff (RESET)
        take && raw_req[grant_idx_reg]);
endmodule // isp_prioritizer
`default_nettype wire

// ---- bench/isp_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module isp_core_model
    import isp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] fetch_delay,
    input wire logic int_request,
    input wire logic [ISP_VEC_W-1:0] vector_addr,
    input wire logic vector_valid,
    output logic cpu_ack,
    output logic cpu_fetch_done,
    output logic [ISP_VEC_W-1:0] got_vec,
    output logic hold_ok,
    output int n_got
);
    logic [ISP_VEC_W-1:0] seen;

    // Accept each offer, read the vector, fetch after a settable delay
    initial begin
        cpu_ack = 1'b0;
        cpu_fetch_done = 1'b0;
        got_vec = 16'h0000;
        hold_ok = 1'b1;
        n_got = 0;
        seen = 16'h0000;
        forever begin
            @(posedge clk);
            if (!rst && int_request === 1'b1) begin
                cpu_ack <= 1'b1;
                @(posedge clk);
                cpu_ack <= 1'b0;
                @(posedge clk);
                // Unknown when nothing is shown, so a compare cannot pass by luck
                seen = (vector_valid === 1'b1) ? vector_addr : 16'hxxxx;
                got_vec <= seen;
                repeat (fetch_delay) @(posedge clk);
                cpu_fetch_done <= 1'b1;
                @(posedge clk);
                cpu_fetch_done <= 1'b0;
                // Vector must still stand at the fetch edge
                if (vector_valid !== 1'b1 || vector_addr !== seen) begin
                    hold_ok <= 1'b0;
                end
                n_got <= n_got + 1;
            end
        end
    end
endmodule // isp_core_model
`default_nettype wire

// ---- bench/isp_prioritizer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module isp_prioritizer_tb;
    import isp_pkg::*;
    // Compare-mode bits of the four eight-bit timers set
    localparam logic [32:0] BASE = 33'h010015000;
    logic clk;
    logic rst;
    logic [32:0] ev;
    logic [ISP_NUM_SRC-1:0] mask;
    logic [3:0] delay;
    logic ack, fetch_done, int_req, vec_valid, hold_ok;
    logic [ISP_VEC_W-1:0] vec_addr, got_vec;
    logic [ISP_NUM_SRC-1:0] flags;
    int n_got;
    int n_fail = 0;
    int comparisons = 0;
    int src_bit [20] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 11, 13, 15, 17, 18, 22, 23, 25, 27, 31, 32};
    logic [15:0] exp_vec [20] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
        16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e,
        16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h002a, 16'h002c, 16'h002e};
    int alt_pin [6] = '{10, 24, 26, 21, 20, 30};
    int alt_mode [6] = '{0, 0, 0, 19, 19, 29};
    int alt_lvl [6] = '{8, 15, 16, 12, 13, 17};
    int sup_pin [8] = '{0, 11, 13, 15, 27, 17, 18, 27};
    int sup_tog [8] = '{1, 12, 14, 16, 28, 19, 19, 29};
    int sup_lvl [8] = '{0, 9, 10, 11, 17, 12, 13, 17};

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    isp_prioritizer dut (
        .CORE_CLK(clk), .RESET(rst),
        .LOW_VOLTAGE_REQUEST(ev[0]), .VOLTAGE_DETECT_MODE_BIT(ev[1]),
        .EXT_PIN_REQUEST_A(ev[2]), .EXT_PIN_REQUEST_B(ev[3]),
        .EXT_PIN_REQUEST_C(ev[4]), .EXT_PIN_REQUEST_D(ev[5]),
        .SERIAL_B_RX_ERROR_REQUEST(ev[6]), .SERIAL_B_RX_DONE_REQUEST(ev[7]),
        .SERIAL_B_TX_DONE_REQUEST(ev[8]), .CLOCKED_SERIAL_DONE_REQUEST(ev[9]),
        .SERIAL_A_TX_DONE_REQUEST(ev[10]), .TIMER_H_ONE_MATCH_REQUEST(ev[11]),
        .TIMER_H_ONE_COMPARE_MODE(ev[12]), .TIMER_H_ZERO_MATCH_REQUEST(ev[13]),
        .TIMER_H_ZERO_COMPARE_MODE(ev[14]), .TIMER_EIGHT_A_MATCH_REQUEST(ev[15]),
        .TIMER_EIGHT_A_COMPARE_MODE(ev[16]), .TIMER16_MATCH_A(ev[17]),
        .TIMER16_MATCH_B(ev[18]), .TIMER16_CAPTURE_MODE(ev[19]),
        .TIMER16_INPUT_PIN_A_EDGE(ev[20]), .TIMER16_INPUT_PIN_B_EDGE(ev[21]),
        .CONVERSION_DONE_REQUEST(ev[22]), .SERIAL_A_RX_DONE(ev[23]),
        .SERIAL_A_RX_ERROR(ev[24]), .RTC_CYCLE(ev[25]), .RTC_ALARM(ev[26]),
        .TIMER_EIGHT_B_MATCH_REQUEST(ev[27]), .TIMER_EIGHT_B_COMPARE_MODE(ev[28]),
        .CARRIER_MODE(ev[29]), .CARRIER_TRANSFER_SIGNAL(ev[30]),
        .KEY_INPUT_REQUEST(ev[31]), .RTC_INTERVAL_REQUEST(ev[32]),
        .SOURCE_MASK(mask), .CPU_ACK(ack), .CPU_FETCH_DONE(fetch_done),
        .INT_REQUEST(int_req), .VECTOR_ADDR(vec_addr), .VECTOR_VALID(vec_valid),
        .PENDING_FLAGS(flags)
    );

    isp_core_model core (
        .clk(clk), .rst(rst), .fetch_delay(delay), .int_request(int_req),
        .vector_addr(vec_addr), .vector_valid(vec_valid), .cpu_ack(ack),
        .cpu_fetch_done(fetch_done), .got_vec(got_vec), .hold_ok(hold_ok), .n_got(n_got)
    );

    task automatic check_vec(input string what, input logic [15:0] expv, input logic [15:0] got);
        comparisons++;
        if (got !== expv) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic check_bit(input string what, input logic expv, input logic got);
        comparisons++;
        if (got !== expv) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, expv, got);
        end
    endtask

    // One-cycle event on one input
    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask

    // Bounded wait for the core's next fetch, then judge its vector
    task automatic fetch(input logic [15:0] expv);
        int k;
        k = n_got;
        for (int i = 0; i < 60 && n_got == k; i++) @(posedge clk);
        check_bit("fetch_count", 1'b1, n_got == k + 1);
        check_vec("vector", expv, got_vec);
    endtask

    task automatic t_range(input int lo, input int hi);
        for (int l = lo; l <= hi; l++) begin
            pulse(src_bit[l]);
            fetch(exp_vec[l]);
        end
    endtask

    // Second sources of shared levels and the mode-switched ones
    task automatic t_alt();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            if (alt_mode[i] != 0) ev[alt_mode[i]] <= 1'b1;
            pulse(alt_pin[i]);
            fetch(exp_vec[alt_lvl[i]]);
            ev <= BASE;
        end
    endtask

    // Wrong mode: event must not even set its flag
    task automatic t_suppress();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ev[sup_tog[i]] <= ~BASE[sup_tog[i]];
            pulse(sup_pin[i]);
            @(negedge clk);
            check_bit("flag_suppressed", 1'b0, flags[sup_lvl[i]]);
            @(posedge clk);
            ev <= BASE;
        end
    endtask

    // All twenty at once, slow core: strict priority order
    task automatic t_priority();
        @(posedge clk);
        delay <= 4'h3;
        for (int l = 0; l < 20; l++) ev[src_bit[l]] <= 1'b1;
        @(posedge clk);
        ev <= BASE;
        for (int l = 0; l < 20; l++) begin
            fetch(exp_vec[l]);
        end
        delay <= 4'h0;
    endtask

    // Masked level pends silently while a lower level is served
    task automatic t_mask();
        @(posedge clk);
        mask <= 20'h00002;
        pulse(src_bit[1]);
        repeat (6) @(posedge clk);
        check_bit("flag_masked", 1'b1, flags[1]);
        check_bit("req_masked", 1'b0, int_req);
        pulse(src_bit[2]);
        fetch(16'h0008);
        mask <= 20'h00000;
        fetch(16'h0006);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        ev = BASE;
        mask = 20'h00000;
        delay = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_bit("reset_state", 1'b1, {flags, vec_valid, int_req, vec_addr} === 38'h0);
        t_range(0, 4);
        t_range(5, 10);
        t_range(11, 19);
        t_alt();
        t_suppress();
        t_priority();
        t_mask();
        check_bit("vector_held", 1'b1, hold_ok);
        end_of_test();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule // isp_prioritizer_tb
`default_nettype wire
